//--- core/ris_pkg.sv
// constants, types and register map of the reset and interrupt sequencer
`default_nettype none
package ris_pkg;
  // ------------------------------------------------------------
  // apb register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] RIS_CAUSE_OFS  = 12'h000;  // reset_cause_register
  localparam logic [11:0] RIS_CFG_OFS    = 12'h004;  // config_reg_one
  localparam logic [11:0] RIS_SVC_OFS    = 12'h008;  // reset vector low byte (watchdog service)
  localparam logic [11:0] RIS_IRQEN_OFS  = 12'h00C;  // per-source interrupt enables
  localparam logic [11:0] RIS_STAT_OFS   = 12'h010;  // live state
  localparam logic [11:0] RIS_PRE_OFS    = 12'h014;  // prescale counter
  // ------------------------------------------------------------
  // reset cause bit positions
  // ------------------------------------------------------------
  localparam int RIS_C_POR  = 7;
  localparam int RIS_C_PIN  = 6;
  localparam int RIS_C_WDOG = 5;
  localparam int RIS_C_BOP  = 4;
  localparam int RIS_C_BAD  = 3;
  localparam int RIS_C_LV   = 1;
  localparam logic [7:0] RIS_CAUSE_POR_VAL = 8'h80;
  // config bits
  localparam int RIS_CFG_SHORT_RECOVERY_BIT = 0;  // short_recovery_bit
  localparam int RIS_CFG_STOPE = 1;  // stop enable
  localparam logic [1:0] RIS_CFG_RST = 2'h0;
  // ------------------------------------------------------------
  // widths, source count and phase counts in osc_ref_clock cycles
  // ------------------------------------------------------------
  localparam int RIS_PRE_W      = 13;
  localparam int RIS_SVC_LOW    = 4;   // bits 12..4 cleared on service
  localparam int RIS_LONG_CYC   = 4096;
  localparam int RIS_SHORT_CYC  = 32;
  localparam int RIS_PIN_CYC    = 32;
  localparam int RIS_TAIL_CYC   = 32;
  localparam int RIS_LV_TAIL    = 64;
  localparam int RIS_WDOG_W     = 8;
  localparam int RIS_NIRQ       = 20;  // sources, index 0 = vector FFD0 (lowest)
  localparam logic [15:0] RIS_VEC_BASE  = 16'hFFD0;
  localparam logic [15:0] RIS_VEC_TRAP  = 16'hFFFC;
  localparam logic [15:0] RIS_VEC_RESET = 16'hFFFE;
  typedef enum logic [2:0] {RIS_RUN, RIS_LONG, RIS_PIN, RIS_TAIL, RIS_STOP, RIS_RECOV}
    ris_state_t;
endpackage
`default_nettype wire

//--- core/ris_top.sv
// reset sequencing, prescale counter, watchdog and interrupt arbitration
//
// Decided for this implementation: the APB register port and the register offsets.
`default_nettype none
// How it works
// [RULE1] power-up sets the power-on cause and clears all others
// [RULE2] reset pin held low throughout power-on stabilization
// [RULE3] watchdog overflow raises internal reset and sets watchdog cause
// [RULE4] every internal source pulls the reset pin low
// [RULE5] service write clears watchdog and prescale bits 12..4
// [RULE6] 13-bit prescale counter advances per osc reference falling edge
// [RULE7] prescale overflow clocks the watchdog counter
// [RULE8] watchdog disabled only by test voltage in monitor or break
// [RULE9] illegal opcode sets bad-opcode cause and resets
// [RULE10] stop with stop-enable clear is an illegal opcode
// [RULE11] only opcode fetches from unmapped addresses reset
// [RULE12] low voltage: pin low 4096 cycles, then 64 more
// [RULE13] stop clears prescale counter, which times recovery; here recovery is timed by the phase counter cnt_reg
// [RULE14] recovery 32 cycles with short bit set, else 4096
// [RULE15] pin reset leaves counter alone; counter free after reset
// [RULE16] latched interrupt holds until serviced or mask cleared
// [RULE17] arbitration result is a constant vector code
// [RULE18] evaluate at instruction end if unmasked and enabled
// [RULE19] highest vector address wins
// [RULE20] entry stacks registers and sets mask; return restores
// [RULE21] high index register not stacked on entry
// [RULE22] software trap ignores mask, stacks current pc
// [RULE23] resets bypass interrupt arbitration
// [RULE24] internal reset: pin low 32 cycles, then 32 more
// [RULE25] reading the cause register clears it
// [RULE26] prescale clock is the buffered oscillator reference
// [RULE27] non-power-on reset sets only its own cause flag
module ris_top
  import ris_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  input  wire logic                    osc_ref_clock,
  input  wire logic                    power_on_pulse,
  input  wire logic                    low_voltage_trip,
  input  wire logic                    rst_pin_in_n,
  output logic                         rst_pin_out,
  output logic                         rst_pin_oe,
  input  wire logic                    test_voltage_rst,
  input  wire logic                    test_voltage_irq,
  input  wire logic                    monitor_mode,
  input  wire logic                    break_state,
  input  wire logic                    illegal_opcode,
  input  wire logic                    stop_exec,
  input  wire logic                    opcode_fetch,
  input  wire logic                    unmapped_access,
  input  wire logic                    insn_done,
  input  wire logic                    int_mask,
  input  wire logic                    trap_exec,
  input  wire logic                    int_ack,
  input  wire logic                    stop_wake,
  input  wire logic [RIS_NIRQ-1:0]     irq_req,
  output logic                         internal_reset_line,
  output logic                         cpu_hold,
  output logic                         int_take,
  output logic [15:0]                  int_vector,
  output logic                         stack_pc_minus_one,
  output logic                         stack_index_high,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr
);
  import ris_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers (pins and oscillator reference)
  // ------------------------------------------------------------
  logic [4:0] s1_reg;
  logic [4:0] s2_reg;
  logic       osc_d_reg;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      s1_reg <= 5'h0F;  // osc bit idles low: no false falling edge after reset
      s2_reg <= 5'h0F;
      osc_d_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= {osc_ref_clock, rst_pin_in_n, ~power_on_pulse, ~low_voltage_trip, 1'b1};
      s2_reg <= s1_reg;
      osc_d_reg <= s2_reg[4];
    end
  wire pin_low  = ~s2_reg[3];
  wire por_evt  = ~s2_reg[2];
  wire lv_evt   = ~s2_reg[1];
  wire osc_tick = osc_d_reg & ~s2_reg[4];  // falling edge of osc reference  [RULE6] [RULE26]

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire rd       = acc & ~pwrite;
  wire hit_cause = paddr == RIS_CAUSE_OFS;
  wire hit_cfg   = paddr == RIS_CFG_OFS;
  wire hit_svc   = paddr == RIS_SVC_OFS;
  wire hit_en    = paddr == RIS_IRQEN_OFS;
  wire hit_stat  = paddr == RIS_STAT_OFS;
  wire hit_pre   = paddr == RIS_PRE_OFS;
  wire mapped    = hit_cause | hit_cfg | hit_svc | hit_en | hit_stat | hit_pre;
  wire svc_wr    = wr & hit_svc;  // any value  [RULE5]
  wire cause_rd  = rd & hit_cause;

  // ------------------------------------------------------------
  // reset sequencer
  // ------------------------------------------------------------
  ris_state_t st_reg;
  logic [12:0] cnt_reg;        // osc ticks within phase
  logic [12:0] pre_reg;
  logic [RIS_WDOG_W-1:0] wd_reg;
  logic [7:0]  cause_reg;
  logic [1:0]  cfg_reg;
  logic [RIS_NIRQ-1:0] en_reg;
  logic        long_tail_reg;  // tail length 64 after long phase
  logic        stop_long_reg;

  wire wd_off    = (monitor_mode & (test_voltage_irq | test_voltage_rst))
                 | (break_state & test_voltage_rst);  // [RULE8]
  wire pre_ovf   = osc_tick & (pre_reg == {RIS_PRE_W{1'b1}});
  wire wd_ovf    = pre_ovf & ~wd_off & (wd_reg == {RIS_WDOG_W{1'b1}});  // [RULE3]
  wire bop_evt   = illegal_opcode | (stop_exec & ~cfg_reg[RIS_CFG_STOPE]);  // [RULE9] [RULE10]
  wire bad_evt   = opcode_fetch & unmapped_access;  // data fetch ignored  [RULE11]
  wire running   = st_reg == RIS_RUN;
  wire short_int = running & (wd_ovf | bop_evt | bad_evt);
  wire long_evt  = por_evt | lv_evt;
  wire stop_go   = running & stop_exec & cfg_reg[RIS_CFG_STOPE];
  wire ph_end_long  = osc_tick & (cnt_reg == 13'(RIS_LONG_CYC - 1));
  wire ph_end_pin   = osc_tick & (cnt_reg == 13'(RIS_PIN_CYC - 1));
  wire ph_end_tail  = osc_tick & (cnt_reg == 13'(long_tail_reg ? RIS_LV_TAIL - 1
                                                                : RIS_TAIL_CYC - 1));
  wire ph_end_rec   = osc_tick & (cnt_reg == 13'(stop_long_reg ? RIS_LONG_CYC - 1
                                                                : RIS_SHORT_CYC - 1));

  // state and phase counter
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      st_reg <= RIS_LONG;
      cnt_reg <= 13'h0000;
      long_tail_reg <= 1'b1;
      stop_long_reg <= 1'b1;
    end
    else if (long_evt)
    begin
      st_reg <= RIS_LONG;  // [RULE2] [RULE12]
      cnt_reg <= 13'h0000;
      long_tail_reg <= 1'b1;
    end
    else if (short_int)
    begin
      st_reg <= RIS_PIN;  // [RULE4] [RULE24]
      cnt_reg <= 13'h0000;
      long_tail_reg <= 1'b0;
    end
    else
      case (st_reg)
        RIS_RUN:
          if (stop_go)
          begin
            st_reg <= RIS_STOP;
            stop_long_reg <= ~cfg_reg[RIS_CFG_SHORT_RECOVERY_BIT];  // [RULE14]
          end
        RIS_LONG:
          if (ph_end_long)
          begin
            st_reg <= RIS_TAIL;
            cnt_reg <= 13'h0000;
          end
          else if (osc_tick)
            cnt_reg <= cnt_reg + 13'h0001;
        RIS_PIN:
          if (ph_end_pin)
          begin
            st_reg <= RIS_TAIL;
            cnt_reg <= 13'h0000;
          end
          else if (osc_tick)
            cnt_reg <= cnt_reg + 13'h0001;
        RIS_TAIL:
          if (ph_end_tail)
            st_reg <= RIS_RUN;
          else if (osc_tick)
            cnt_reg <= cnt_reg + 13'h0001;
        RIS_STOP:
          if (stop_wake | pin_low)
          begin
            st_reg <= RIS_RECOV;
            cnt_reg <= 13'h0000;
          end
        RIS_RECOV:
          if (ph_end_rec)
            st_reg <= RIS_RUN;  // [RULE13] [RULE14]
          else if (osc_tick)
            cnt_reg <= cnt_reg + 13'h0001;
        default:
          st_reg <= RIS_RUN;
      endcase

  // prescale counter: free-running, external pin reset has no effect
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      pre_reg <= 13'h0000;
    else if (long_evt | short_int | stop_go | st_reg == RIS_STOP)
      pre_reg <= 13'h0000;  // internal reset or stop clears  [RULE13] [RULE15]
    else if (svc_wr)
      pre_reg <= {9'h000, pre_reg[RIS_SVC_LOW-1:0]};  // [RULE5]
    else if (osc_tick)
      pre_reg <= pre_reg + 13'h0001;  // [RULE6]

  // watchdog counter clocked by prescale overflow
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      wd_reg <= '0;
    else if (svc_wr | ~running)
      wd_reg <= '0;  // [RULE5]
    else if (pre_ovf & ~wd_off)
      wd_reg <= wd_reg + 1'b1;  // [RULE7]

  // reset cause: set wins over read-clear
  logic [7:0] cause_set;
  assign cause_set = {por_evt, pin_low & running, wd_ovf & running, bop_evt & running,
                      bad_evt & running, 1'b0, lv_evt, 1'b0};
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      cause_reg <= RIS_CAUSE_POR_VAL;
    else if (por_evt)
      cause_reg <= RIS_CAUSE_POR_VAL;  // [RULE1]
    else if (|cause_set)
      cause_reg <= (cause_rd ? 8'h00 : cause_reg) | cause_set;  // [RULE27]
    else if (cause_rd)
      cause_reg <= 8'h00;  // [RULE25]

  // configuration and enables
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      cfg_reg <= RIS_CFG_RST;
      en_reg <= '0;
    end
    else if (wr & hit_cfg)
      cfg_reg <= pwdata[1:0];
    else if (wr & hit_en)
      en_reg <= pwdata[RIS_NIRQ-1:0];

  assign rst_pin_out = 1'b0;  // open drain, drives low only
  assign rst_pin_oe  = (st_reg == RIS_LONG) | (st_reg == RIS_PIN);  // [RULE2] [RULE4]
  assign internal_reset_line = (st_reg == RIS_LONG) | (st_reg == RIS_PIN)
                             | (st_reg == RIS_TAIL) | pin_low;  // [RULE23]
  assign cpu_hold = ~running;

  // ------------------------------------------------------------
  // interrupt latch and arbitration
  // ------------------------------------------------------------
  logic        lat_v_reg;
  logic [15:0] vec_reg;
  logic        trap_reg;
  wire [RIS_NIRQ-1:0] live = irq_req & en_reg;  // [RULE18]
  function automatic logic [4:0] ris_top_idx(input logic [RIS_NIRQ-1:0] v);
    ris_top_idx = 5'h00;
    for (int i = 0; i < RIS_NIRQ; i++)
      if (v[i])
        ris_top_idx = 5'(i);  // highest index wins  [RULE19]
  endfunction
  wire [4:0]  win  = ris_top_idx(live);
  wire [15:0] wvec = RIS_VEC_BASE + {10'h000, win, 1'b0};
  wire hw_take = insn_done & ~int_mask & (|live) & running;  // [RULE18]
  wire sw_take = trap_exec & running;  // mask ignored  [RULE22]

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      lat_v_reg <= 1'b0;
      vec_reg <= RIS_VEC_RESET;
      trap_reg <= 1'b0;
    end
    else if (internal_reset_line)
    begin
      lat_v_reg <= 1'b0;
      vec_reg <= RIS_VEC_RESET;  // resets skip arbitration  [RULE23]
    end
    else if (lat_v_reg)
    begin
      if (int_ack | (~int_mask & ~trap_reg & ~(|live)))
        lat_v_reg <= 1'b0;  // held until serviced or, unless a trap, until no enabled request remains with mask clear  [RULE16]
    end
    else if (sw_take)
    begin
      lat_v_reg <= 1'b1;
      vec_reg <= RIS_VEC_TRAP;
      trap_reg <= 1'b1;
    end
    else if (hw_take)
    begin
      lat_v_reg <= 1'b1;
      vec_reg <= wvec;  // [RULE16] [RULE17]
      trap_reg <= 1'b0;
    end

  assign int_take = lat_v_reg;  // cpu stacks and sets mask on entry  [RULE20]
  assign int_vector = vec_reg;  // [RULE17]
  assign stack_pc_minus_one = lat_v_reg & ~trap_reg;  // [RULE22]
  assign stack_index_high = 1'b0;  // [RULE21]

  // ------------------------------------------------------------
  // apb read path
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  assign rd_mux = hit_cause ? {24'h000000, cause_reg}
                : hit_cfg   ? {30'h0, cfg_reg}
                : hit_en    ? {12'h000, en_reg}
                : hit_stat  ? {24'h0, wd_reg[7:0]} | {16'h0, 5'h0, 3'(st_reg), 8'h0}
                : hit_pre   ? {19'h0, pre_reg}
                : 32'h0000_0000;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata <= rd_mux;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
endmodule // ris_top
`default_nettype wire

//--- test/ris_top_sva.sv
// port assertions for the reset and interrupt sequencer
`default_nettype none
module ris_top_chk
  import ris_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        rst_pin_out,
  input wire logic        rst_pin_oe,
  input wire logic        internal_reset_line,
  input wire logic        illegal_opcode,
  input wire logic        opcode_fetch,
  input wire logic        unmapped_access,
  input wire logic        int_ack,
  input wire logic        int_take,
  input wire logic [15:0] int_vector,
  input wire logic        stack_index_high,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_pin; rst_pin_out == 1'b0; endproperty
  a_pin: assert property (p_pin)
    else $error("reset pin driven high");
  property p_oe; rst_pin_oe |-> internal_reset_line; endproperty
  a_oe: assert property (p_oe)
    else $error("pin low without internal reset");
  property p_bop; illegal_opcode && !internal_reset_line |-> ##[1:4] rst_pin_oe; endproperty
  a_bop: assert property (p_bop)
    else $error("bad opcode did not reset");
  property p_bad;
    opcode_fetch && unmapped_access && !internal_reset_line |-> ##[1:4] rst_pin_oe;
  endproperty
  a_bad: assert property (p_bad)
    else $error("bad fetch did not reset");
  property p_hold; $rose(rst_pin_oe) |=> rst_pin_oe [*8]; endproperty
  a_hold: assert property (p_hold)
    else $error("reset pin pulse too short");
  property p_tail; $fell(rst_pin_oe) |-> internal_reset_line [*8]; endproperty
  a_tail: assert property (p_tail)
    else $error("internal reset tail missing");
  property p_vec; int_take && !int_ack |=> !int_take || $stable(int_vector); endproperty
  a_vec: assert property (p_vec)
    else $error("latched vector changed");
  property p_idx; stack_index_high == 1'b0; endproperty
  a_idx: assert property (p_idx)
    else $error("high index stacked");
  property p_err; psel && penable && paddr > RIS_PRE_OFS |-> pslverr; endproperty
  a_err: assert property (p_err)
    else $error("unmapped access not refused");
endmodule // ris_top_chk
`default_nettype wire

//--- test/ris_far.sv
// far side: oscillator reference and pulled-up reset pin
`default_nettype none
module ris_far
(
  input  wire logic rst_pin_oe,
  output var logic  osc_ref_clock,
  output logic      rst_pin_in_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // buffered oscillator, 80 ns period, phase unrelated to mclk
  initial
  begin
    osc_ref_clock = 1'b0;
    #7;
    forever #40 osc_ref_clock = ~osc_ref_clock;
  end
  // pull-up holds the pin high unless the device pulls it low
  assign rst_pin_in_n = ~rst_pin_oe;
endmodule // ris_far
`default_nettype wire

//--- test/ris_top_tb.sv
// self-checking bench for the reset and interrupt sequencer
`default_nettype none
module ris_top_tb
  import ris_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 0, nrst = 0, osc_ref_clock, rst_pin_in_n, rst_pin_out, rst_pin_oe;
  logic        power_on_pulse = 0, low_voltage_trip = 0, illegal_opcode = 0;
  logic        stop_exec = 0, opcode_fetch = 0, unmapped_access = 0, insn_done = 0;
  logic        int_mask = 1, trap_exec = 0, int_ack = 0, internal_reset_line, cpu_hold;
  logic        int_take, stack_pc_minus_one, stack_index_high, pready, pslverr, perr;
  logic        psel = 0, penable = 0, pwrite = 0, stop_wake = 0;
  logic [19:0] irq_req = '0;
  logic [15:0] int_vector;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, d, d2;
  int          err_total, checked, cyc, n, m;
  always #10 mclk = ~mclk;
  ris_far ris_far_inst (.rst_pin_oe, .osc_ref_clock, .rst_pin_in_n);
  ris_top ris_top_inst (.mclk, .nrst, .osc_ref_clock, .power_on_pulse, .low_voltage_trip,
    .rst_pin_in_n, .rst_pin_out, .rst_pin_oe, .test_voltage_rst(1'b0),
    .test_voltage_irq(1'b0), .monitor_mode(1'b0), .break_state(1'b0), .illegal_opcode,
    .stop_exec, .opcode_fetch, .unmapped_access, .insn_done, .int_mask, .trap_exec,
    .int_ack, .stop_wake, .irq_req, .internal_reset_line, .cpu_hold, .int_take,
    .int_vector, .stack_pc_minus_one, .stack_index_high, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rng(input int v, input int e);
    checked++;
    if (v < e - 12 || v > e + 12)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: count %0d want %0d", $time, v, e);
    end
  endtask
  // one apb transfer, released on the edge that samples pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    d = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // fire one reset source, time pin and tail in mclk cycles, read the cause
  task automatic src(input int k, input int pt, input int tt, input logic [31:0] c);
    case (k)
      0: illegal_opcode <= 1'b1;
      1: {opcode_fetch, unmapped_access} <= 2'b11;
      2: stop_exec <= 1'b1;
      default: low_voltage_trip <= 1'b1;
    endcase
    @(posedge mclk);
    {illegal_opcode, opcode_fetch, unmapped_access, stop_exec, low_voltage_trip} <= '0;
    n = 0;
    m = 0;
    while (rst_pin_oe !== 1'b1) @(posedge mclk);
    while (rst_pin_oe === 1'b1)
    begin
      n++;
      @(posedge mclk);
    end
    while (internal_reset_line === 1'b1)
    begin
      m++;
      @(posedge mclk);
    end
    rng(n, pt * 4);
    rng(m, tt * 4);
    apb(1'b0, RIS_CAUSE_OFS, '0);
    chk(d, c);
    $display("test reset source %0d done", k);
  endtask
  // end an instruction, then wait a bounded time for a taken interrupt
  task automatic insn(input logic t);
    trap_exec <= t;
    insn_done <= 1'b1;
    @(posedge mclk);
    trap_exec <= 1'b0;
    insn_done <= 1'b0;
    for (n = 0; n < 8 && int_take !== 1'b1; n++) @(posedge mclk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: timeout", $time);
      close_out();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({31'b0, rst_pin_oe}, 32'h1);
    while (internal_reset_line === 1'b1) @(posedge mclk);
    chk({31'b0, cpu_hold}, 32'h0);
    apb(1'b0, RIS_CAUSE_OFS, '0);
    chk(d, {24'h0, RIS_CAUSE_POR_VAL});
    apb(1'b0, RIS_CAUSE_OFS, '0);
    chk(d, 32'h0);
    unmapped_access <= 1'b1;
    @(posedge mclk);
    unmapped_access <= 1'b0;
    repeat (8) @(posedge mclk);
    chk({31'b0, internal_reset_line}, 32'h0);
    $display("test power-on done");
    src(0, RIS_PIN_CYC, RIS_TAIL_CYC, 32'h10);
    src(1, RIS_PIN_CYC, RIS_TAIL_CYC, 32'h08);
    apb(1'b1, RIS_CFG_OFS, '0);
    src(2, RIS_PIN_CYC, RIS_TAIL_CYC, 32'h10);
    src(3, RIS_LONG_CYC, RIS_LV_TAIL, 32'h02);
    // stop with short recovery, woken by an interrupt
    apb(1'b1, RIS_CFG_OFS, 32'h0000_0003);
    stop_exec <= 1'b1;
    @(posedge mclk);
    stop_exec <= 1'b0;
    @(posedge mclk);
    chk({31'b0, cpu_hold}, 32'h1);
    stop_wake <= 1'b1;
    @(posedge mclk);
    stop_wake <= 1'b0;
    n = 0;
    while (cpu_hold === 1'b1 && n < 9000)
    begin
      n++;
      @(posedge mclk);
    end
    rng(n, RIS_SHORT_CYC * 4);
    $display("test stop recovery done");
    apb(1'b1, RIS_SVC_OFS, 32'h0000_0000);
    apb(1'b0, RIS_PRE_OFS, '0);
    chk({31'b0, d[12:0] < 13'h0018}, 32'h1);
    d2 = d;
    repeat (40) @(posedge mclk);
    apb(1'b0, RIS_PRE_OFS, '0);
    chk({31'b0, d[12:0] > d2[12:0]}, 32'h1);
    apb(1'b0, 12'h100, '0);
    chk({31'b0, perr}, 32'h1);
    $display("test prescaler done");
    apb(1'b1, RIS_IRQEN_OFS, 32'h000F_FFFF);
    irq_req <= 20'h0_0021;
    int_mask <= 1'b0;
    insn(1'b0);
    chk({15'h0, int_take, int_vector}, 32'h0001_FFDA);
    irq_req <= 20'h0_0421;
    insn(1'b0);
    chk({15'h0, int_take, int_vector}, 32'h0001_FFDA);
    int_ack <= 1'b1;
    irq_req <= '0;
    int_mask <= 1'b1;
    @(posedge mclk);
    int_ack <= 1'b0;
    irq_req <= 20'h0_0008;
    insn(1'b0);
    chk({31'b0, int_take}, 32'h0);
    irq_req <= '0;
    insn(1'b1);
    chk({14'h0, int_take, stack_pc_minus_one, int_vector}, 32'h0002_FFFC);
    chk({31'b0, stack_index_high}, 32'h0);
    $display("test interrupts done");
    close_out();
  end
endmodule // ris_top_tb
bind ris_top ris_top_chk ris_top_chk_inst (.mclk, .nrst, .rst_pin_out, .rst_pin_oe,
  .internal_reset_line, .illegal_opcode, .opcode_fetch, .unmapped_access, .int_ack,
  .int_take, .int_vector, .stack_index_high, .psel, .penable, .paddr, .pslverr);
`default_nettype wire
